// ==== verilog/trm_consts.svh ====
// Purpose: Constants for the trigger matched readout of one front-end chip.
// Assumes: 25 MHz system clock; hit time stamps count system clock cycles.
// Notes:   Buffer depth is set here so a longer trigger latency only needs a new depth.
`ifndef TRM_CONSTS_SVH
`define TRM_CONSTS_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define TRM_CLK_NS        40
`define TRM_LAT_NS        1000000
// Retention is a least time, so the cycle count rounds up.
`define TRM_LAT_CYC       ((`TRM_LAT_NS + `TRM_CLK_NS - 1) / `TRM_CLK_NS)
`define TRM_WIN_NS        75
// Half of the selection window, rounded up to whole cycles.
`define TRM_HALF_WIN_CYC  ((`TRM_WIN_NS + 2 * `TRM_CLK_NS - 1) / (2 * `TRM_CLK_NS))

// ==========================================================================
// Hit buffer and hit word layout
// ==========================================================================
`define TRM_ADDR_W        15
`define TRM_LANES         4
`define TRM_HIT_W         48
`define TRM_TS_W          24
`define TRM_TS_LSB        24
`define TRM_THROTTLE_LVL  15'h7000

// ==========================================================================
// Slow serial links: start bit, 16 data bits LSB first, even parity, stop bit
// ==========================================================================
`define TRM_SER_DIV       25
`define TRM_SER_HALF      12
`define TRM_FRAME_LAST    18
`define TRM_KIND_TEMP     4'h1
`define TRM_KIND_ACK      4'h2
`define TRM_KIND_RDBK     4'h3

`endif

// ==== verilog/trm_pkg.sv ====
// Purpose: Types shared by the trigger matched readout.
// Assumes: Constants come from trm_consts.svh.
// Notes:   Holds the one-hot state encoding of the readout sequencer.
package trm_pkg;

    // ======================================================================
    // Sequencer states
    // ======================================================================
    typedef enum logic [5:0] {
        TRM_IDLE = 6'h01,
        TRM_TCHK = 6'h02,
        TRM_XRD  = 6'h04,
        TRM_XCHK = 6'h08,
        TRM_XOUT = 6'h10,
        TRM_TRL  = 6'h20
    } trm_state_e;

endpackage

// ==== verilog/trm_hit_ram.sv ====
// Purpose: Circular hit store, one write port and one registered read port.
// Assumes: Read data appear one cycle after the read enable.
// Notes:   No reset on the array; contents are only read behind the write pointer.
`timescale 1ns/1ps
`include "trm_consts.svh"

module trm_hit_ram (
    input  wire logic                   clk_i,    // System clock.
    input  wire logic                   we_i,     // Write enable.
    input  wire logic [`TRM_ADDR_W-1:0] waddr_i,  // Write address.
    input  wire logic [`TRM_HIT_W-1:0]  wdata_i,  // Write data.
    input  wire logic                   re_i,     // Read enable.
    input  wire logic [`TRM_ADDR_W-1:0] raddr_i,  // Read address.
    output logic      [`TRM_HIT_W-1:0]  rdata_o   // Registered read data.
);

    logic [`TRM_HIT_W-1:0] mem [0:(1 << `TRM_ADDR_W)-1];
    logic [`TRM_HIT_W-1:0] rdata_ff;

    // ======================================================================
    // Storage
    // ======================================================================
    // Write and read share the clock; a read of the word being written returns the old value.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        if (re_i) begin
            rdata_ff <= mem[raddr_i];
        end
    end

    assign rdata_o = rdata_ff;

endmodule // trm_hit_ram

// ==== verilog/trm_readout.sv ====
// Purpose: Trigger matched readout for one front-end chip.
// Assumes: Hit lanes and trigger come from logic on clk_i; status link is a raw pin.
// Notes:   Event data go out on two acquisition links, alternating per trigger.
`timescale 1ns/1ps
`include "trm_consts.svh"

// Notes on behaviour
// - Keep every hit for the trigger latency.
// - Select hits within 75 ns around event.
// - Buffer depth scales through one constant.
// - Accept two to four data lanes.
// - Receive status frames and forward them.
// - Decode temperature, acknowledge and read-back frames.
// - Check hit and status streams, report errors.
// - Drive clock link and configuration link.
// - Configuration goes out on this chip's link.
// - Time tag locates the slice when given.
// - Throttle when buffers near overflow.
// - Flag data loss, request reset if repeated.
// - Download configuration and verify read-back.
// - Temperature outside limits drives interlock directly.
// - Push selected data over two links.
module trm_readout #(
    parameter int unsigned LAT_CYC = `TRM_LAT_CYC  // Trigger latency in cycles.
) (
    input  wire logic                             clk_i,            // 25 MHz clock.
    input  wire logic                             reset_i,          // Synchronous reset, high.
    input  wire logic [`TRM_LANES-1:0]            lane_en_i,        // Lanes in use.
    input  wire logic [`TRM_LANES-1:0]            hit_valid_i,      // Hit word valid per lane.
    input  wire logic [`TRM_LANES*`TRM_HIT_W-1:0] hit_data_i,       // Hit words, lane 0 lowest.
    output logic      [`TRM_LANES-1:0]            hit_ready_o,      // Hit word taken per lane.
    input  wire logic                             trig_i,           // First level trigger pulse.
    input  wire logic                             trig_tag_valid_i, // Trigger carries a time tag.
    input  wire logic [`TRM_TS_W-1:0]             trig_tag_i,       // Trigger time tag.
    output logic                                  throttle_o,       // Buffers near overflow or trigger waiting.
    output logic                                  error_o,          // Data has been lost.
    output logic                                  reset_req_o,      // Loss again while flagged.
    input  wire logic                             err_clear_i,      // Clears error flags.
    output logic      [1:0]                       acq_valid_o,      // Word valid per link.
    input  wire logic [1:0]                       acq_ready_i,      // Link accepts word.
    output logic      [`TRM_HIT_W-1:0]            acq_data_o,       // Event word.
    output logic                                  acq_last_o,       // Event trailer word.
    input  wire logic                             stat_rx_i,        // Status link pin.
    output logic                                  stat_valid_o,     // Good status frame pulse.
    output logic      [15:0]                      stat_word_o,      // Last good status frame.
    output logic                                  stat_err_o,       // Bad status frame pulse.
    output logic                                  hit_err_o,        // Hit from the future pulse.
    input  wire logic [11:0]                      temp_lo_i,        // Lower temperature limit.
    input  wire logic [11:0]                      temp_hi_i,        // Upper temperature limit.
    output logic                                  interlock_o,      // Temperature out of limits.
    input  wire logic                             cfg_valid_i,      // Configuration word valid.
    input  wire logic [15:0]                      cfg_word_i,       // Configuration word.
    output logic                                  cfg_ready_o,      // Configuration link idle.
    output logic                                  cfg_tx_o,         // Configuration link pin.
    output logic                                  clk_link_o,       // Clock link to the chip.
    output logic                                  verify_ok_o,      // Read-back matched pulse.
    output logic                                  verify_err_o      // Read-back mismatch pulse.
);

    localparam logic signed [`TRM_TS_W-1:0] HALF_S = `TRM_TS_W'(`TRM_HALF_WIN_CYC);
    localparam logic signed [`TRM_TS_W-1:0] KEEP_S = `TRM_TS_W'(LAT_CYC + `TRM_HALF_WIN_CYC);
    localparam logic [`TRM_TS_W-1:0]        LAT_TS = `TRM_TS_W'(LAT_CYC);

    // Modular time difference, valid while the two stamps are less than half a wrap apart.
    function automatic logic signed [`TRM_TS_W-1:0] ts_diff(input logic [`TRM_TS_W-1:0] a,
                                                            input logic [`TRM_TS_W-1:0] b);
        return a - b;
    endfunction

    // Round robin pick: the start lane has priority, then the following lanes.
    function automatic logic [2:0] rr_pick(input logic [3:0] req, input logic [1:0] start);
        logic [2:0] res;
        logic [1:0] idx;
        res = 3'h0;
        for (int k = 3; k >= 0; k--) begin
            idx = start + 2'(k);
            if (req[idx]) begin
                res = {1'b1, idx};
            end
        end
        return res;
    endfunction

    trm_pkg::trm_state_e         state_ff, nxt_state;
    logic [`TRM_ADDR_W-1:0]      wr_ff, tail_ff, nxt_tail, scan_ff, nxt_scan;
    logic [`TRM_TS_W-1:0]        now_ff, ev_ff, nxt_ev, pend_ev_ff, trig_cnt_ff;
    logic [`TRM_HIT_W-1:0]       out_ff, nxt_out, rdata;
    logic                        last_ff, nxt_last, sel_ff, nxt_sel, pend_ff, take_pend;
    logic [1:0]                  rr_ff;
    logic                        err_ff, rreq_ff, thr_ff, hit_err_ff, clk_link_ff;

    // ======================================================================
    // Hit intake and circular buffer
    // ======================================================================
    wire [2:0]                   pick      = rr_pick(hit_valid_i & lane_en_i, rr_ff);
    wire                         hit_take  = pick[2];
    wire [`TRM_HIT_W-1:0]        hit_word  = hit_data_i[32'(pick[1:0]) * `TRM_HIT_W +: `TRM_HIT_W];
    wire [`TRM_ADDR_W-1:0]       fill      = wr_ff - tail_ff;
    wire                         full      = &fill;
    wire                         hit_store = hit_take & ~full;
    wire                         hit_lost  = hit_take & full;
    wire                         trig_lost = trig_i & pend_ff & ~take_pend;
    wire                         loss      = hit_lost | trig_lost;
    wire                         st_idle   = (state_ff == trm_pkg::TRM_IDLE);
    wire                         st_xrd    = (state_ff == trm_pkg::TRM_XRD);
    wire                         rd_en     = (st_idle & ~pend_ff & (tail_ff != wr_ff)) |
                                             (st_xrd & (scan_ff != wr_ff));
    wire [`TRM_ADDR_W-1:0]       rd_addr   = st_xrd ? scan_ff : tail_ff;
    wire [`TRM_TS_W-1:0]         rd_ts     = rdata[`TRM_TS_LSB +: `TRM_TS_W];
    wire signed [`TRM_TS_W-1:0]  d_ev      = ts_diff(rd_ts, ev_ff);
    wire signed [`TRM_TS_W-1:0]  age       = ts_diff(now_ff, rd_ts);
    wire signed [`TRM_TS_W-1:0]  d_hit     = ts_diff(hit_word[`TRM_TS_LSB +: `TRM_TS_W], now_ff);
    wire                         acq_go    = |(acq_valid_o & acq_ready_i);

    // Only the picked lane is taken each cycle; a full buffer does not stall it but drops its hit, and other valid lanes wait.
    assign hit_ready_o = hit_take ? (4'h1 << pick[1:0]) : 4'h0;

    // Depth comes from one constant, so a longer latency is a change of that constant.
    trm_hit_ram u_ram (
        .clk_i   (clk_i),
        .we_i    (hit_store),
        .waddr_i (wr_ff),
        .wdata_i (hit_word),
        .re_i    (rd_en),
        .raddr_i (rd_addr),
        .rdata_o (rdata)
    );

    // ======================================================================
    // Sequencer: retire old hits, extract event windows
    // ======================================================================
    always_comb begin
        nxt_state = state_ff;
        nxt_tail  = tail_ff;
        nxt_scan  = scan_ff;
        nxt_ev    = ev_ff;
        nxt_out   = out_ff;
        nxt_last  = last_ff;
        nxt_sel   = sel_ff;
        take_pend = 1'b0;
        unique case (state_ff)
            trm_pkg::TRM_IDLE: begin
                if (pend_ff) begin
                    take_pend = 1'b1;
                    nxt_scan  = tail_ff;
                    nxt_ev    = pend_ev_ff;
                    nxt_state = trm_pkg::TRM_XRD;
                end else if (tail_ff != wr_ff) begin
                    nxt_state = trm_pkg::TRM_TCHK;
                end
            end
            trm_pkg::TRM_TCHK: begin
                if (age > KEEP_S) begin
                    nxt_tail = tail_ff + 1'b1;
                end
                nxt_state = trm_pkg::TRM_IDLE;
            end
            trm_pkg::TRM_XRD: begin
                if (scan_ff == wr_ff) begin
                    nxt_out   = {ev_ff, trig_cnt_ff};
                    nxt_last  = 1'b1;
                    nxt_state = trm_pkg::TRM_TRL;
                end else begin
                    nxt_state = trm_pkg::TRM_XCHK;
                end
            end
            trm_pkg::TRM_XCHK: begin
                if (d_ev > HALF_S) begin
                    nxt_out   = {ev_ff, trig_cnt_ff};
                    nxt_last  = 1'b1;
                    nxt_state = trm_pkg::TRM_TRL;
                end else begin
                    nxt_scan = scan_ff + 1'b1;
                    if (d_ev >= -HALF_S) begin
                        nxt_out   = rdata;
                        nxt_last  = 1'b0;
                        nxt_state = trm_pkg::TRM_XOUT;
                    end else begin
                        nxt_state = trm_pkg::TRM_XRD;
                    end
                end
            end
            trm_pkg::TRM_XOUT: begin
                if (acq_go) begin
                    nxt_state = trm_pkg::TRM_XRD;
                end
            end
            trm_pkg::TRM_TRL: begin
                if (acq_go) begin
                    nxt_sel   = ~sel_ff;
                    nxt_state = trm_pkg::TRM_IDLE;
                end
            end
        endcase
    end

    // Each event goes out whole on one link; the next event takes the other link.
    assign acq_valid_o = ((state_ff == trm_pkg::TRM_XOUT) | (state_ff == trm_pkg::TRM_TRL)) ?
                         (sel_ff ? 2'h2 : 2'h1) : 2'h0;
    assign acq_data_o  = out_ff;
    assign acq_last_o  = last_ff;

    // Sequencer and buffer pointer registers.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= trm_pkg::TRM_IDLE;
            wr_ff    <= '0;
            tail_ff  <= '0;
            scan_ff  <= '0;
            ev_ff    <= '0;
            out_ff   <= '0;
            last_ff  <= 1'b0;
            sel_ff   <= 1'b0;
            rr_ff    <= 2'h0;
            now_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            wr_ff    <= hit_store ? wr_ff + 1'b1 : wr_ff;
            tail_ff  <= nxt_tail;
            scan_ff  <= nxt_scan;
            ev_ff    <= nxt_ev;
            out_ff   <= nxt_out;
            last_ff  <= nxt_last;
            sel_ff   <= nxt_sel;
            rr_ff    <= hit_take ? pick[1:0] + 2'h1 : rr_ff;
            now_ff   <= now_ff + 1'b1;
        end
    end

    // ======================================================================
    // Trigger capture, throttle and loss flags
    // ======================================================================
    // One trigger waits while an event is read out; a further one overwrites the waiting one, and the loss is flagged.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pend_ff     <= 1'b0;
            pend_ev_ff  <= '0;
            trig_cnt_ff <= '0;
            err_ff      <= 1'b0;
            rreq_ff     <= 1'b0;
            thr_ff      <= 1'b0;
            hit_err_ff  <= 1'b0;
        end else begin
            if (trig_i) begin
                pend_ff     <= 1'b1;
                pend_ev_ff  <= trig_tag_valid_i ? trig_tag_i : now_ff - LAT_TS;
                trig_cnt_ff <= trig_cnt_ff + 1'b1;
            end else if (take_pend) begin
                pend_ff <= 1'b0;
            end
            err_ff     <= loss | (err_ff & ~err_clear_i);
            rreq_ff    <= (loss & err_ff) | (rreq_ff & ~err_clear_i);
            thr_ff     <= (fill >= `TRM_THROTTLE_LVL) | pend_ff;
            hit_err_ff <= hit_take & (d_hit > 0);
        end
    end

    assign throttle_o  = thr_ff;
    assign error_o     = err_ff;
    assign reset_req_o = rreq_ff;
    assign hit_err_o   = hit_err_ff;

    // ======================================================================
    // Status link receiver and decoder
    // ======================================================================
    logic        rx_s1_ff, rx_s2_ff, rx_busy_ff, rx_done_ff, rx_stop_ff;
    logic [4:0]  rx_cnt_ff, rx_bit_ff;
    logic [16:0] rx_sh_ff;
    logic        st_val_ff, st_err_ff, ilk_ff, vok_ff, verr_ff;
    logic [15:0] st_word_ff, last_cfg_ff;
    wire  [3:0]  rx_kind  = rx_sh_ff[15:12];
    wire  [11:0] rx_val   = rx_sh_ff[11:0];
    wire         rx_known = (rx_kind == `TRM_KIND_TEMP) | (rx_kind == `TRM_KIND_ACK) |
                            (rx_kind == `TRM_KIND_RDBK);
    wire         rx_good  = rx_done_ff & rx_stop_ff & ~(^rx_sh_ff) & rx_known;

    // The pin is synchronised first; bits are sampled in the middle of each bit time.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_s1_ff   <= 1'b1;
            rx_s2_ff   <= 1'b1;
            rx_busy_ff <= 1'b0;
            rx_done_ff <= 1'b0;
            rx_stop_ff <= 1'b0;
            rx_cnt_ff  <= '0;
            rx_bit_ff  <= '0;
            rx_sh_ff   <= '0;
        end else begin
            rx_s1_ff   <= stat_rx_i;
            rx_s2_ff   <= rx_s1_ff;
            rx_done_ff <= 1'b0;
            if (!rx_busy_ff) begin
                if (!rx_s2_ff) begin
                    rx_busy_ff <= 1'b1;
                    rx_cnt_ff  <= 5'(`TRM_SER_HALF);
                    rx_bit_ff  <= '0;
                end
            end else if (rx_cnt_ff != 5'h0) begin
                rx_cnt_ff <= rx_cnt_ff - 1'b1;
            end else begin
                rx_cnt_ff <= 5'(`TRM_SER_DIV - 1);
                rx_bit_ff <= rx_bit_ff + 1'b1;
                if (rx_bit_ff == 5'h0) begin
                    rx_busy_ff <= ~rx_s2_ff;               // A glitch is not a start bit.
                end else if (rx_bit_ff == 5'(`TRM_FRAME_LAST)) begin
                    rx_busy_ff <= 1'b0;
                    rx_done_ff <= 1'b1;
                    rx_stop_ff <= rx_s2_ff;
                end else begin
                    rx_sh_ff <= {rx_s2_ff, rx_sh_ff[16:1]};
                end
            end
        end
    end

    // Frames are judged as they end; the interlock level needs no host to act.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_val_ff  <= 1'b0;
            st_err_ff  <= 1'b0;
            st_word_ff <= '0;
            ilk_ff     <= 1'b0;
            vok_ff     <= 1'b0;
            verr_ff    <= 1'b0;
        end else begin
            st_val_ff <= rx_good;
            st_err_ff <= rx_done_ff & ~rx_good;
            vok_ff    <= rx_good & (rx_kind == `TRM_KIND_RDBK) &
                         (rx_val == last_cfg_ff[11:0]);
            verr_ff   <= rx_good & (rx_kind == `TRM_KIND_RDBK) &
                         (rx_val != last_cfg_ff[11:0]);
            if (rx_good) begin
                st_word_ff <= rx_sh_ff[15:0];
            end
            if (rx_good & (rx_kind == `TRM_KIND_TEMP)) begin
                ilk_ff <= (rx_val > temp_hi_i) | (rx_val < temp_lo_i);
            end
        end
    end

    assign stat_valid_o = st_val_ff;
    assign stat_err_o   = st_err_ff;
    assign stat_word_o  = st_word_ff;
    assign interlock_o  = ilk_ff;
    assign verify_ok_o  = vok_ff;
    assign verify_err_o = verr_ff;

    // ======================================================================
    // Configuration link transmitter and clock link
    // ======================================================================
    logic        tx_busy_ff, tx_line_ff;
    logic [4:0]  tx_cnt_ff, tx_bit_ff;
    logic [18:0] tx_sh_ff;

    // One word at a time; the host waits on cfg_ready_o rather than a queue.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_busy_ff  <= 1'b0;
            tx_line_ff  <= 1'b1;
            tx_cnt_ff   <= '0;
            tx_bit_ff   <= '0;
            tx_sh_ff    <= '0;
            last_cfg_ff <= '0;
            clk_link_ff <= 1'b0;
        end else begin
            clk_link_ff <= ~clk_link_ff;
            if (!tx_busy_ff) begin
                if (cfg_valid_i) begin
                    tx_busy_ff  <= 1'b1;
                    tx_sh_ff    <= {1'b1, ^cfg_word_i, cfg_word_i, 1'b0};
                    tx_line_ff  <= 1'b0;
                    tx_cnt_ff   <= 5'(`TRM_SER_DIV - 1);
                    tx_bit_ff   <= '0;
                    last_cfg_ff <= cfg_word_i;
                end
            end else if (tx_cnt_ff != 5'h0) begin
                tx_cnt_ff <= tx_cnt_ff - 1'b1;
            end else if (tx_bit_ff == 5'(`TRM_FRAME_LAST)) begin
                tx_busy_ff <= 1'b0;
            end else begin
                tx_cnt_ff  <= 5'(`TRM_SER_DIV - 1);
                tx_bit_ff  <= tx_bit_ff + 1'b1;
                tx_line_ff <= tx_sh_ff[1];
                tx_sh_ff   <= tx_sh_ff >> 1;
            end
        end
    end

    assign cfg_ready_o = ~tx_busy_ff;
    assign cfg_tx_o    = tx_line_ff;
    assign clk_link_o  = clk_link_ff;

endmodule // trm_readout

// ==== tb/trm_readout_props.sv ====
// Purpose: Port assertions for trm_readout.
// Assumes: One clock, reset_i synchronous and high.
// Notes:   Frame length is checked as one exact range.
`timescale 1ns/1ps
// ==========================================================================
// Checker
// ==========================================================================
module trm_readout_props (
    input wire logic clk_i, reset_i, cfg_valid_i, cfg_ready_o, cfg_tx_o, clk_link_o, // Clock, reset, config.
    input wire logic error_o, err_clear_i, stat_valid_o, stat_err_o, interlock_o,   // Flags.
    input wire logic verify_ok_o, verify_err_o,                                     // Verify pulses.
    input wire logic [3:0] lane_en_i, hit_valid_i, hit_ready_o,                     // Hit lanes.
    input wire logic [1:0] acq_valid_o, acq_ready_i,                                // Event links.
    input wire logic [47:0] acq_data_o                                              // Event word.
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // A frame starts on the edge where a word is taken.
    sequence s_cfg_take; cfg_valid_i && cfg_ready_o; endsequence
    chk_cfg_start: assert property (s_cfg_take |=> !cfg_tx_o && !cfg_ready_o) else $error("no start bit");
    chk_cfg_length: assert property (s_cfg_take ##1 !cfg_ready_o |-> ##[474:474] !cfg_ready_o ##1 cfg_ready_o)
        else $error("config frame length wrong");
    chk_link_toggle: assert property (!$past(reset_i) |-> clk_link_o != $past(clk_link_o)) else $error("no toggle");
    chk_hit_grant: assert property ($onehot0(hit_ready_o) && (hit_ready_o & ~(hit_valid_i & lane_en_i)) == 4'h0)
        else $error("bad hit grant");
    chk_acq_hold: assert property (acq_valid_o != 2'b00 && (acq_valid_o & acq_ready_i) == 2'b00 |=>
        acq_valid_o == $past(acq_valid_o) && $stable(acq_data_o)) else $error("event word dropped");
    chk_acq_single: assert property ($onehot0(acq_valid_o)) else $error("two links valid");
    chk_err_sticky: assert property (error_o && !err_clear_i |=> error_o) else $error("error flag lost");
    chk_stat_excl: assert property (!(stat_valid_o && stat_err_o)) else $error("good and bad frame");
    chk_lock_cause: assert property ($rose(interlock_o) |-> stat_valid_o) else $error("interlock uncaused");
    chk_verify_cause: assert property (verify_ok_o || verify_err_o |-> stat_valid_o && !(verify_ok_o && verify_err_o))
        else $error("verify pulse wrong");
endmodule // trm_readout_props

bind trm_readout trm_readout_props u_props (.*);

// ==== tb/trm_acq_sink.sv ====
// Purpose: Acquisition network sink for the two event links.
// Assumes: The readout holds each word until it is taken.
// Notes:   Accepts every other cycle at best, so holding is exercised.
`timescale 1ns/1ps
// ==========================================================================
// Sink
// ==========================================================================
module trm_acq_sink (
    input  wire logic       clk_i,   // System clock.
    input  wire logic [1:0] valid_i, // Word valid per link.
    output logic      [1:0] ready_o  // Word taken per link.
);
    // Ready drops after each take, which stalls the next word a cycle.
    always_ff @(posedge clk_i) ready_o <= valid_i & ~ready_o;
endmodule // trm_acq_sink

// ==== tb/trm_readout_bench.sv ====
// Purpose: Self-checking bench for trm_readout.
// Assumes: Latency shortened to 64 cycles; inputs change at falling edges.
// Notes:   Event test runs first, before the short retention expires.
`timescale 1ns/1ps
// ==========================================================================
// Bench
// ==========================================================================
module trm_readout_bench;
    logic clk_i = 0;
    logic reset_i, trig_i, trig_tag_valid_i, err_clear_i, stat_rx_i, cfg_valid_i, throttle_o, error_o, reset_req_o;
    logic acq_last_o, stat_valid_o, stat_err_o, hit_err_o, interlock_o, cfg_ready_o, cfg_tx_o, clk_link_o;
    logic verify_ok_o, verify_err_o;
    logic [3:0] lane_en_i, hit_valid_i, hit_ready_o;
    logic [191:0] hit_data_i;
    logic [23:0] trig_tag_i;
    logic [1:0] acq_valid_o, acq_ready_i;
    logic [47:0] acq_data_o;
    logic [15:0] stat_word_o, cfg_word_i;
    logic [11:0] temp_lo_i, temp_hi_i;
    int err_count, check_count, n, k;
    always #20 clk_i = ~clk_i;
    trm_readout #(.LAT_CYC(64)) i_dut (.*);
    trm_acq_sink i_sink (.clk_i, .valid_i(acq_valid_o), .ready_o(acq_ready_i));
    task chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Hits 3..10 stored, tagged trigger at 6 must yield 5, 6, 7 and a trailer.
    task t_event;
        for (int i = 3; i <= 10; i++) begin hit_valid_i = 4'h1; hit_data_i[47:0] = {24'(i), 24'(i)}; @(negedge clk_i); end
        hit_valid_i = 4'h0; trig_tag_i = 24'h6; trig_tag_valid_i = 1; trig_i = 1; @(negedge clk_i);
        trig_i = 0; trig_tag_valid_i = 0; k = 0;
        for (n = 0; n < 300 && k < 4; n++) begin
            @(negedge clk_i);
            if ((acq_valid_o & acq_ready_i) != 2'b00) begin
                chk(acq_valid_o, 2'b01);
                if (k < 3) chk(acq_data_o[47:24], 5 + k);
                else chk({acq_last_o, acq_data_o[47:24]}, {1'b1, 24'h6});
                k++;
            end
        end
        chk(k, 4);
        chk(error_o, 0);
    endtask
    // One configuration word; the link stays busy for the whole frame.
    task t_cfg;
        cfg_word_i = 16'h0abc; cfg_valid_i = 1; @(negedge clk_i); cfg_valid_i = 0;
        chk({cfg_ready_o, cfg_tx_o}, 0);
        for (n = 0; n < 600 && !cfg_ready_o; n++) @(negedge clk_i);
        chk(n, 475);
    endtask
    task send_stat(input logic [15:0] d, input logic bad);
        logic [18:0] f;
        f = {1'b1, ^d ^ bad, d, 1'b0};
        for (int i = 0; i < 19; i++) begin stat_rx_i = f[i]; repeat (25) @(negedge clk_i); end
        repeat (6) @(negedge clk_i);
    endtask
    // Hot, normal, corrupt and read-back frames.
    task t_status;
        send_stat(16'h1900, 0); chk({interlock_o, stat_word_o}, 17'h1_1900);
        send_stat(16'h1400, 0); chk({interlock_o, stat_word_o}, 17'h0_1400);
        send_stat(16'h2555, 1); chk(stat_word_o, 16'h1400);
        send_stat(16'h3abc, 0); chk(stat_word_o, 16'h3abc);
    endtask
    initial begin
        {reset_i, trig_i, trig_tag_valid_i, err_clear_i, cfg_valid_i, hit_valid_i} = 9'h100;
        {stat_rx_i, lane_en_i, hit_data_i, trig_tag_i, cfg_word_i} = {5'h13, 232'h0};
        temp_lo_i = 12'h100; temp_hi_i = 12'h800; err_count = 0; check_count = 0;
        repeat (2) @(negedge clk_i); reset_i = 0;
        repeat (12) @(negedge clk_i);
        t_event; t_cfg; t_status; report_and_stop;
    end
endmodule // trm_readout_bench
